// ==== design/dcache_invalidate_fetch_ctrl.sv ====
// config register lower bits: flash invalidate, fetch and touch controls
`timescale 1ns/1ps
`include "hw_impl_config_0_regs.svh"

// Behaviour
// - flash clear invalidates all blocks, no write-back
// - hardware clears flash bit next cycle, cache enabled
// - flash clear does nothing while cache disabled
// - cache access blocked during invalidate
// - bus accesses answered miss during invalidate
// - invalidate clears valid bits, tree to L0
// - bit set sends indirect branch fetch external
// - bit set turns touch instructions into no-ops
// - reserved bits carry no function, read zero
// - source select picks table or mode field
// - hard reset table picks clock output source
module dcache_invalidate_fetch_ctrl import dcache_ctrl_pkg::*; #(
  parameter int SETS = `DC_SETS,
  parameter int WAYS = `DC_WAYS,
  parameter int SETW = $clog2(SETS)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // special register move port
  input wire spr_req_s spr_req,
  output logic [31:0] spr_rd_data_q,
  // core data cache access
  input wire logic core_req,
  input wire logic [SETW-1:0] core_set,
  output logic core_grant_q,
  // peripheral logic bus cache access
  input wire logic plb_req,
  output logic plb_miss_q,
  // line fill from the miss path
  input wire logic fill_en,
  input wire logic [SETW-1:0] fill_set,
  input wire logic [1:0] fill_way,
  // lookup result
  output logic [WAYS-1:0] look_valid_q,
  output logic [`DC_PLRU_W-1:0] look_plru_q,
  // invalidate in progress
  output logic flash_busy_q,
  // fetch and touch controls
  output logic branch_ext_fetch_q,
  output logic touch_noop_q,
  // clock output selection
  input wire clk_ctrl_s clk_ctrl,
  output clk_src_e clk_out_src_q,
  output logic clk_out_oe_q
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q; // first stage, read only by the second
  logic rst_n; // synchronised reset used everywhere else

  // assert at once, release two edges later
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ****************************************
  // config register
  // ****************************************
  logic [31:0] hic0_q; // stored register value
  logic [31:0] hic0_d; // next register value
  logic [31:0] wr_clean; // write data with reserved bits dropped
  logic wr_flash; // software writes a one to the flash bit
  logic dce; // data cache enable
  logic flash_pend; // flash request waiting in the register
  logic sweep_busy; // tag sweep running
  logic flash_start; // pulse that launches the sweep

  assign wr_clean = spr_req.wr_data & ~`HIC0_RSV_MASK;
  assign wr_flash = spr_req.wr_en && spr_req.wr_data[`HIC0_FLASH_BIT];
  assign dce = hic0_q[`HIC0_DCE_BIT];
  assign flash_pend = hic0_q[`HIC0_FLASH_BIT];
  // start only with the cache on; a sweep already running finishes first
  assign flash_start = flash_pend && dce && !sweep_busy;

  // software write, then hardware self-clear of the flash bit
  always_comb begin
    hic0_d = hic0_q;
    if (spr_req.wr_en) begin
      hic0_d = wr_clean;
    end
    // a fresh write of one beats the self-clear of the old request
    if (flash_start && !wr_flash) begin
      hic0_d[`HIC0_FLASH_BIT] = 1'b0;
    end
  end

  // register storage; reserved bits never leave zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hic0_q <= `HIC0_RESET;
    end else begin
      hic0_q <= hic0_d;
    end
  end

  // ****************************************
  // tag state and flash sweep
  // ****************************************
  logic [SETW-1:0] look_set; // set presented to the lookup

  // fills are the only other writer, so the sweep is never overtaken
  assign look_set = core_set;

  dcache_tag_state #(
    .SETS(SETS),
    .WAYS(WAYS),
    .SETW(SETW)
  ) u_tags (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sweep_start(flash_start),
    .busy_q(sweep_busy),
    .fill_en(fill_en),
    .fill_set(fill_set),
    .fill_way(fill_way),
    .look_set(look_set),
    .look_valid_q(look_valid_q),
    .look_plru_q(look_plru_q)
  );

  // ****************************************
  // access gating and registered outputs
  // ****************************************
  logic block_now; // sweep running or starting this cycle
  logic grant_d; // core access may proceed
  logic miss_d; // bus access forced to miss

  // blocking covers the launch cycle too, so no access slips in
  assign block_now = sweep_busy || flash_start;
  assign grant_d = core_req && !block_now;
  assign miss_d = plb_req && block_now;

  // all outputs leave from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_grant_q <= 1'b0;
      plb_miss_q <= 1'b0;
      flash_busy_q <= 1'b0;
      branch_ext_fetch_q <= 1'b0;
      touch_noop_q <= 1'b0;
      spr_rd_data_q <= '0;
    end else begin
      core_grant_q <= grant_d;
      plb_miss_q <= miss_d;
      flash_busy_q <= block_now;
      branch_ext_fetch_q <= hic0_d[`HIC0_BRANCH_EXT_BIT];
      touch_noop_q <= hic0_d[`HIC0_TOUCH_OFF_BIT];
      spr_rd_data_q <= hic0_d;
    end
  end

  // ****************************************
  // clock output source
  // ****************************************
  // the pin mux and divider live at the pad; only the code is made here
  clk_out_select u_clk_sel (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ctrl(clk_ctrl),
    .src_q(clk_out_src_q),
    .oe_q(clk_out_oe_q)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_self_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      flash_pend && dce && !sweep_busy && !spr_req.wr_en
        |=> !flash_pend;
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("flash bit not cleared after launch");

  property p_no_sweep_disabled;
    @(posedge clk_sys) disable iff (!rst_n)
      !dce && !sweep_busy |=> !sweep_busy;
  endproperty
  a_no_sweep_disabled: assert property (p_no_sweep_disabled)
    else $error("sweep started with cache disabled");

  property p_sweep_length;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(sweep_busy) |-> sweep_busy [*8];
  endproperty
  a_sweep_length: assert property (p_sweep_length)
    else $error("sweep ended early");

  property p_block_core;
    @(posedge clk_sys) disable iff (!rst_n)
      sweep_busy && core_req |=> !core_grant_q && flash_busy_q;
  endproperty
  a_block_core: assert property (p_block_core)
    else $error("core access granted during invalidate");

  property p_bus_miss;
    @(posedge clk_sys) disable iff (!rst_n)
      (sweep_busy || flash_start) && plb_req |=> plb_miss_q;
  endproperty
  a_bus_miss: assert property (p_bus_miss)
    else $error("bus access not answered as miss");

  property p_no_miss_idle;
    @(posedge clk_sys) disable iff (!rst_n)
      !flash_busy_q |-> !plb_miss_q;
  endproperty
  a_no_miss_idle: assert property (p_no_miss_idle)
    else $error("miss reported outside invalidate");

  property p_branch_ext;
    @(posedge clk_sys) disable iff (!rst_n)
      spr_req.wr_en |=>
        branch_ext_fetch_q == $past(spr_req.wr_data[`HIC0_BRANCH_EXT_BIT]);
  endproperty
  a_branch_ext: assert property (p_branch_ext)
    else $error("branch fetch control does not follow write");

  property p_touch_off;
    @(posedge clk_sys) disable iff (!rst_n)
      spr_req.wr_en |=>
        touch_noop_q == $past(spr_req.wr_data[`HIC0_TOUCH_OFF_BIT]);
  endproperty
  a_touch_off: assert property (p_touch_off)
    else $error("touch control does not follow write");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (spr_rd_data_q & `HIC0_RSV_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit reads as one");

  property p_hrst_sys;
    @(posedge clk_sys) disable iff (!rst_n)
      !clk_ctrl.clock_out_source_select && !clk_ctrl.hrst_cpu_n
        |=> clk_out_src_q == CLK_OUT_SYS && clk_out_oe_q;
  endproperty
  a_hrst_sys: assert property (p_hrst_sys)
    else $error("clock output not system clock in reset");

  property p_mode_field;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_ctrl.clock_out_source_select |=>
        clk_out_src_q == clk_src_e'($past(clk_ctrl.clock_out_mode_field));
  endproperty
  a_mode_field: assert property (p_mode_field)
    else $error("mode field not followed");

  property p_hiz_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !clk_ctrl.clock_out_source_select && clk_ctrl.hrst_cpu_n &&
      clk_ctrl.hrst_ctrl_n && !clk_ctrl.sysclk_out_enable &&
      !clk_ctrl.core_clock_out_enable |=> !clk_out_oe_q;
  endproperty
  a_hiz_off: assert property (p_hiz_off)
    else $error("clock output driven when both enables off");

endmodule : dcache_invalidate_fetch_ctrl

// ==== design/hw_impl_config_0_regs.svh ====
// bit positions, reset values and sizes of the implementation config register
`ifndef HW_IMPL_CONFIG_0_REGS_SVH
`define HW_IMPL_CONFIG_0_REGS_SVH

// ****************************************
// register layout (vector index = 31 - documented big-endian bit number)
// ****************************************
`define HIC0_RESET 32'h0000_0000
`define HIC0_DCE_BIT 14
`define HIC0_FLASH_BIT 10
`define HIC0_BRANCH_EXT_BIT 4
`define HIC0_TOUCH_OFF_BIT 0
// documented bits 22-26 and 28-30 are reserved, read as zero
`define HIC0_RSV_MASK 32'h0000_03ee

// ****************************************
// cache geometry defaults
// ****************************************
`define DC_SETS 128
`define DC_WAYS 4
`define DC_PLRU_W 3

`endif

// ==== design/dcache_ctrl_pkg.sv ====
// types shared by the flash invalidate and clock output logic
package dcache_ctrl_pkg;

  // clock output source, encoded like the enable pair {core, sys}
  typedef enum logic [1:0] {
    CLK_OUT_HIZ = 2'b00,
    CLK_OUT_SYS_DIV2 = 2'b01,
    CLK_OUT_CORE = 2'b10,
    CLK_OUT_SYS = 2'b11
  } clk_src_e;

  // move-to / move-from special register port
  typedef struct packed {
    logic wr_en;
    logic [31:0] wr_data;
  } spr_req_s;

  // everything that picks the clock output source
  typedef struct packed {
    logic clock_out_source_select;
    logic [1:0] clock_out_mode_field;
    logic sysclk_out_enable;
    logic core_clock_out_enable;
    logic hrst_cpu_n;
    logic hrst_ctrl_n;
  } clk_ctrl_s;

endpackage : dcache_ctrl_pkg

// ==== design/dcache_tag_state.sv ====
// data cache valid bits and pseudo-lru bits with a set-by-set flash sweep
`timescale 1ns/1ps
`include "hw_impl_config_0_regs.svh"

module dcache_tag_state import dcache_ctrl_pkg::*; #(
  parameter int SETS = `DC_SETS,
  parameter int WAYS = `DC_WAYS,
  parameter int SETW = $clog2(SETS)
) (
  // clock and synchronised reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // sweep control
  input wire logic sweep_start,
  output logic busy_q,
  // line fill from the miss path
  input wire logic fill_en,
  input wire logic [SETW-1:0] fill_set,
  input wire logic [1:0] fill_way,
  // lookup
  input wire logic [SETW-1:0] look_set,
  output logic [WAYS-1:0] look_valid_q,
  output logic [`DC_PLRU_W-1:0] look_plru_q
);

  // ****************************************
  // state arrays
  // ****************************************
  logic [WAYS-1:0] valid_mem [SETS]; // one valid bit per block
  logic [`DC_PLRU_W-1:0] plru_mem [SETS]; // tree bits, zero selects L0
  logic [SETW-1:0] idx_q; // sweep position
  logic last_set; // sweep reaches its final set
  logic [`DC_PLRU_W-1:0] plru_next; // tree after a fill

  assign last_set = (idx_q == SETW'(SETS - 1));
  // point the tree away from the way just filled
  assign plru_next = {~fill_way[1],
                      fill_way[1] ? plru_mem[fill_set][1] : ~fill_way[0],
                      fill_way[1] ? ~fill_way[0] : plru_mem[fill_set][0]};

  // ****************************************
  // sweep, fill and lookup
  // ****************************************
  // one set per cycle keeps the clear logic to a single row of flops;
  // modified blocks are dropped without any write-back
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      idx_q <= '0;
      look_valid_q <= '0;
      look_plru_q <= '0;
      for (int i = 0; i < SETS; i++) begin
        valid_mem[i] <= '0;
        plru_mem[i] <= '0;
      end
    end else begin
      look_valid_q <= valid_mem[look_set];
      look_plru_q <= plru_mem[look_set];
      if (busy_q) begin
        valid_mem[idx_q] <= '0;
        plru_mem[idx_q] <= '0;
        idx_q <= idx_q + 1'b1;
        if (last_set) begin
          busy_q <= 1'b0;
        end
      end else if (sweep_start) begin
        busy_q <= 1'b1;
        idx_q <= '0;
      end else if (fill_en) begin
        // fills are held off while the sweep runs
        valid_mem[fill_set][fill_way] <= 1'b1;
        plru_mem[fill_set] <= plru_next;
      end
    end
  end

  // swept set is invalid with the tree on L0 one cycle later
  property p_sweep_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      busy_q |=> (valid_mem[$past(idx_q)] == '0) &&
                 (plru_mem[$past(idx_q)] == '0);
  endproperty
  a_sweep_clears: assert property (p_sweep_clears)
    else $error("swept set not cleared");

endmodule : dcache_tag_state

// ==== design/clk_out_select.sv ====
// picks the clock output source from enables, hard reset or mode field
`timescale 1ns/1ps

module clk_out_select import dcache_ctrl_pkg::*; (
  // clock and synchronised reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // selection inputs
  input wire clk_ctrl_s ctrl,
  // chosen source and pin drive
  output clk_src_e src_q,
  output logic oe_q
);

  // ****************************************
  // selection
  // ****************************************
  logic hrst_on; // either hard reset input asserted
  clk_src_e table_src; // source from the enable pair
  clk_src_e src_d; // final choice

  assign hrst_on = !ctrl.hrst_cpu_n || !ctrl.hrst_ctrl_n;
  assign table_src = hrst_on ? CLK_OUT_SYS :
                     clk_src_e'({ctrl.core_clock_out_enable,
                                 ctrl.sysclk_out_enable});
  assign src_d = ctrl.clock_out_source_select ?
                 clk_src_e'(ctrl.clock_out_mode_field) :
                 table_src;

  // registered so the pin mux sees a glitch-free code
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= CLK_OUT_SYS;
      oe_q <= 1'b1;
    end else begin
      src_q <= src_d;
      oe_q <= (src_d != CLK_OUT_HIZ);
    end
  end

endmodule : clk_out_select

// ==== sim/core_bus_model.sv ====
// far side model: core pipeline and bus requesters of the data cache
`timescale 1ns/1ps

module core_bus_model (
  // clock
  input wire logic clk_sys,
  // request control from the bench
  input wire logic go,
  // requests toward the cache
  output logic core_req = 1'b0,
  output logic plb_req = 1'b0
);
  // ****************************************
  // request drive
  // ****************************************
  // both requests are levels, moved only just after an edge
  always @(posedge clk_sys) begin
    core_req <= go;
    plb_req <= go;
  end
endmodule : core_bus_model

// ==== sim/dcache_invalidate_fetch_ctrl_test.sv ====
// self-checking bench for the flash invalidate and fetch control block
`timescale 1ns/1ps

module dcache_invalidate_fetch_ctrl_test import dcache_ctrl_pkg::*;;
  // ****************************************
  // signals
  // ****************************************
  localparam int SETS = 8; // short sweep keeps the run brief
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  spr_req_s spr_req = '0;
  logic [31:0] spr_rd_data_q;
  logic core_req, core_grant_q, plb_req, plb_miss_q;
  logic [2:0] core_set = 3'h0;
  logic fill_en = 1'b0; // line fill strobe
  logic [2:0] fill_set = 3'h0;
  logic [1:0] fill_way = 2'h0;
  logic [3:0] look_valid_q;
  logic [2:0] look_plru_q;
  logic flash_busy_q, branch_ext_fetch_q, touch_noop_q, clk_out_oe_q;
  clk_ctrl_s clk_ctrl = '0; // hard reset asserted at start
  clk_src_e clk_out_src_q;
  logic req_go = 1'b0; // far side request enable
  int num_errors = 0;
  int tests_run = 0;

  // ****************************************
  // instances
  // ****************************************
  dcache_invalidate_fetch_ctrl #(.SETS(SETS)) dcache_invalidate_fetch_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .spr_req(spr_req),
    .spr_rd_data_q(spr_rd_data_q), .core_req(core_req),
    .core_set(core_set), .core_grant_q(core_grant_q), .plb_req(plb_req),
    .plb_miss_q(plb_miss_q), .fill_en(fill_en), .fill_set(fill_set),
    .fill_way(fill_way), .look_valid_q(look_valid_q),
    .look_plru_q(look_plru_q), .flash_busy_q(flash_busy_q),
    .branch_ext_fetch_q(branch_ext_fetch_q), .touch_noop_q(touch_noop_q),
    .clk_ctrl(clk_ctrl), .clk_out_src_q(clk_out_src_q),
    .clk_out_oe_q(clk_out_oe_q)
  );
  core_bus_model core_bus_model_inst (
    .clk_sys(clk_sys), .go(req_go), .core_req(core_req), .plb_req(plb_req)
  );

  // ****************************************
  // clock and watchdog
  // ****************************************
  // 50 mhz system clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // a hung wait ends the run here instead of spinning forever
  initial begin
    #200000;
    num_errors++;
    $display("ERROR watchdog expired");
    wrap_up();
  end

  // ****************************************
  // helpers
  // ****************************************
  // count a compare and report a mismatch
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one move-to-register write, single cycle strobe
  task automatic wr(input logic [31:0] data);
    @(posedge clk_sys);
    spr_req <= '{1'b1, data};
    @(posedge clk_sys);
    spr_req.wr_en <= 1'b0;
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // ****************************************
  // scenarios
  // ****************************************
  // all ones but enable and flash: reserved bits read back zero, controls follow their bits
  task automatic t_bits();
    wr(32'hffff_bbff);
    cyc(2);
    chk("rd all", 32'hffff_b811, spr_rd_data_q);
    chk("branch on", 32'h1, 32'(branch_ext_fetch_q));
    chk("touch on", 32'h1, 32'(touch_noop_q));
    wr(32'h0);
    cyc(2);
    chk("branch off", 32'h0, 32'(branch_ext_fetch_q));
    chk("touch off", 32'h0, 32'(touch_noop_q));
  endtask : t_bits

  // fill a line, then flash with the cache off, then with it on and requests running
  task automatic t_flash();
    int n = 0; // cycles seen with the invalidate running
    @(posedge clk_sys);
    fill_en <= 1'b1;
    fill_set <= 3'h3;
    fill_way <= 2'h1;
    core_set <= 3'h3;
    @(posedge clk_sys);
    fill_en <= 1'b0;
    cyc(3);
    chk("filled", 32'h2, {28'h0, look_valid_q});
    // tree must have moved, else the later l0 check proves nothing
    chk("plru moved", 32'h1, 32'(look_plru_q != 3'h0));
    wr(32'h0000_0400); // flash bit alone, cache disabled
    cyc(4);
    chk("idle busy", 32'h0, 32'(flash_busy_q));
    chk("flash held", 32'h1, 32'(spr_rd_data_q[10]));
    chk("kept line", 32'h2, {28'h0, look_valid_q});
    req_go <= 1'b1;
    wr(32'h0000_4400);
    // launch is decided in this cycle, the flops show it an edge later
    @(posedge clk_sys);
    chk("launch held", 32'h1, 32'(spr_rd_data_q[10]));
    @(posedge clk_sys);
    chk("launch busy", 32'h1, 32'(flash_busy_q));
    chk("self clear", 32'h0, 32'(spr_rd_data_q[10]));
    for (int i = 0; i < SETS + 4 && flash_busy_q === 1'b1; i++) begin
      n++;
      chk("blocked", 32'h0, 32'(core_grant_q));
      chk("bus miss", 32'h1, 32'(plb_miss_q));
      @(posedge clk_sys);
    end
    chk("sweep end", 32'h0, 32'(flash_busy_q));
    // launch cycle plus one cycle per set
    chk("sweep len", 32'(SETS + 1), 32'(n));
    cyc(2);
    chk("granted", 32'h1, 32'(core_grant_q));
    chk("no miss", 32'h0, 32'(plb_miss_q));
    chk("invalid", 32'h0, {28'h0, look_valid_q});
    chk("plru l0", 32'h0, {29'h0, look_plru_q});
    req_go <= 1'b0;
  endtask : t_flash

  // clock output source from enable table, hard reset and mode field
  task automatic t_clk();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      @(posedge clk_sys);
      clk_ctrl <= '{1'b0, ~c, c[0], c[1], 1'b1, 1'b1};
      cyc(3);
      chk("table src", {30'h0, c}, 32'(clk_out_src_q));
      chk("table oe", {31'h0, c != 2'h0}, 32'(clk_out_oe_q));
      @(posedge clk_sys);
      clk_ctrl <= '{1'b1, c, ~c[0], ~c[1], 1'b1, 1'b1};
      cyc(3);
      chk("mode src", {30'h0, c}, 32'(clk_out_src_q));
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      clk_ctrl <= '{1'b0, 2'h0, 1'b0, 1'b0, i[0], ~i[0]};
      cyc(3);
      chk("hrst src", 32'h3, 32'(clk_out_src_q));
    end
  endtask : t_clk

  // ****************************************
  // closing
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cyc(3);
    chk("reset rd", 32'h0, spr_rd_data_q);
    chk("reset src", 32'h3, 32'(clk_out_src_q));
    nrst <= 1'b1;
    cyc(4);
    t_bits();
    t_flash();
    t_clk();
    wrap_up();
  end
endmodule : dcache_invalidate_fetch_ctrl_test
